/* hdl/uri_top.sv */
// Purpose: Register interface of a simple asynchronous serial port
// Assumes: Classic Wishbone slave, one clock, inputs synchronous
// Notes: Minimal 8-bit engines give the flags real behaviour
`timescale 1ns/1ps
module uri_top
	import uri_pkg::*;
(
	input wire logic clock,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic serial_in_pin,
	output logic serial_out_pin,
	input wire logic rx_dma_done,
	input wire logic tx_dma_done,
	input wire logic tx_dma_buffer_empty,
	input wire logic rx_dma_buffer_full,
	output logic irq_out
);
	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic hits(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] ofs);
		hits = (a[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
	endfunction

	// Shared by both engines so sender and checker always agree
	function automatic logic check_bit(input logic [2:0] kind,
		input logic [7:0] d);
		logic r;
		r = 1'h0;
		case (kind)
			CHK_EVEN: r = ^d;
			CHK_ODD: r = ~^d;
			CHK_SPACE: r = 1'h0;
			CHK_MARK: r = 1'h1;
			default: r = 1'h0;
		endcase
		check_bit = r;
	endfunction

	function automatic logic has_check(input logic [2:0] kind);
		has_check = (kind < CHK_NONE);
	endfunction

	uri_state_t s;
	uri_state_t n;
	logic req;
	logic wr;
	logic rd;
	logic [31:0] wmask;
	logic [31:0] wdat;
	logic cmd_wr;
	logic ier_wr;
	logic idr_wr;
	logic rhr_rd;
	logic [31:0] ier_bits;
	logic [31:0] idr_bits;
	logic [31:0] stat;
	logic [31:0] mode_word;
	logic irq_src;
	logic rx_in;

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_lane
			assign wmask[g*8 +: 8] = {8{wb_sel_i[g]}};
		end
	endgenerate

	// ****************************************
	// Bus decode
	// ****************************************
	assign req = wb_cyc_i & wb_stb_i & ~s.ack;
	assign wr = req & wb_we_i;
	assign rd = req & ~wb_we_i;
	// Unselected lanes count as zero, so they cause no command
	assign wdat = wb_dat_i & wmask;
	assign cmd_wr = wr & hits(wb_adr_i, OFS_COMMAND);
	assign ier_wr = wr & hits(wb_adr_i, OFS_IRQ_ENABLE);
	assign idr_wr = wr & hits(wb_adr_i, OFS_IRQ_DISABLE);
	assign rhr_rd = rd & hits(wb_adr_i, OFS_RX_HOLDING);
	assign ier_bits = wdat & IRQ_VALID;
	assign idr_bits = wdat & IRQ_VALID;

	// ****************************************
	// Status word
	// ****************************************
	always_comb begin
		stat = 32'h0000_0000;
		stat[RECEIVER_READY_FLAG_BIT] = s.rx_ready & s.rx_on;
		stat[HOLDING_FREE_FLAG_BIT] = s.tx_on & ~s.thr_full;
		stat[RX_DMA_DONE_FLAG_BIT] = rx_dma_done;
		stat[TX_DMA_DONE_FLAG_BIT] = tx_dma_done;
		stat[OVERRUN_FLAG_BIT] = s.ovr;
		stat[FRAMING_FLAG_BIT] = s.frm;
		stat[PARITY_ERROR_FLAG_BIT] = s.perr;
		stat[TRANSMIT_IDLE_FLAG_BIT] = s.tx_on & ~s.thr_full &
			(s.tx_st == TX_IDLE);
		stat[TX_DMA_BUFFER_EMPTY_FLAG_BIT] = tx_dma_buffer_empty;
		stat[RX_DMA_BUFFER_FULL_FLAG_BIT] = rx_dma_buffer_full;
	end

	assign irq_src = |(stat & s.mask);

	always_comb begin
		mode_word = MODE_RESET;
		mode_word[CHECK_BIT_KIND_LSB +: 3] = s.chk;
		mode_word[CHANNEL_TEST_SELECT_LSB +: 2] = s.chan;
	end

	// Remote loopback starves the receiver with an idle line
	always_comb begin
		case (s.chan)
			CH_LOCAL: rx_in = s.tx_line;
			CH_REMOTE: rx_in = 1'h1;
			default: rx_in = serial_in_pin;
		endcase
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic [31:0] mv;
		mv = 32'h0000_0000;
		n = s;
		n.ack = req;
		n.dat = 32'h0000_0000;

		// Clears first, so a same-cycle event still sets its flag
		if (cmd_wr && wdat[STATUS_CLEAR_CMD_BIT]) begin
			n.ovr = 1'h0;
			n.frm = 1'h0;
			n.perr = 1'h0;
		end
		if (rhr_rd) begin
			n.rx_ready = 1'h0;
		end

		// Baud tick, sixteen per bit
		n.tick = 1'h0;
		if (s.divisor == BAUD_RESET) begin
			n.div_cnt = BAUD_RESET;
		end else if (s.div_cnt >= s.divisor - 16'h0001) begin
			n.div_cnt = BAUD_RESET;
			n.tick = 1'h1;
		end else begin
			n.div_cnt = s.div_cnt + 16'h0001;
		end

		// Transmit engine
		if (s.tick) begin
			if (s.tx_st == TX_IDLE) begin
				if (s.tx_on && s.thr_full) begin
					n.tx_shift = s.thr;
					n.tx_chk = check_bit(s.chk, s.thr);
					n.thr_full = 1'h0;
					n.tx_st = TX_START;
					n.tx_sub = 4'h0;
					n.tx_line = 1'h0;
				end
			end else if (s.tx_sub != TICK_LAST) begin
				n.tx_sub = s.tx_sub + 4'h1;
			end else begin
				n.tx_sub = 4'h0;
				case (s.tx_st)
					TX_START: begin
						n.tx_st = TX_DATA;
						n.tx_bit = 3'h0;
						n.tx_line = s.tx_shift[0];
					end
					TX_DATA: begin
						n.tx_shift = {1'h0, s.tx_shift[7:1]};
						if (s.tx_bit != DATA_BITS_LAST) begin
							n.tx_bit = s.tx_bit + 3'h1;
							n.tx_line = s.tx_shift[1];
						end else if (has_check(s.chk)) begin
							n.tx_st = TX_CHECK;
							n.tx_line = s.tx_chk;
						end else begin
							n.tx_st = TX_STOP;
							n.tx_line = 1'h1;
						end
					end
					TX_CHECK: begin
						n.tx_st = TX_STOP;
						n.tx_line = 1'h1;
					end
					default: begin
						n.tx_st = TX_IDLE;
						n.tx_line = 1'h1;
					end
				endcase
			end
		end
		// Held and shifting characters drain before the stop
		if (s.tx_stop_pend && n.tx_st == TX_IDLE && !n.thr_full) begin
			n.tx_on = 1'h0;
			n.tx_stop_pend = 1'h0;
		end

		// Receive engine
		if (s.tick && s.rx_on) begin
			case (s.rx_st)
				RX_IDLE: begin
					if (rx_in) begin
						n.rx_sub = 4'h0;
					end else if (s.rx_sub == START_LOW_LAST) begin
						n.rx_st = RX_DATA;
						n.rx_sub = 4'h0;
						n.rx_bit = 3'h0;
					end else begin
						n.rx_sub = s.rx_sub + 4'h1;
					end
				end
				default: begin
					if (s.rx_sub != TICK_LAST) begin
						n.rx_sub = s.rx_sub + 4'h1;
					end else begin
						n.rx_sub = 4'h0;
						case (s.rx_st)
							RX_DATA: begin
								n.rx_shift = {rx_in, s.rx_shift[7:1]};
								n.rx_bit = s.rx_bit + 3'h1;
								if (s.rx_bit == DATA_BITS_LAST) begin
									n.rx_st = has_check(s.chk) ?
										RX_CHECK : RX_STOP;
								end
							end
							RX_CHECK: begin
								n.rx_chk = rx_in;
								n.rx_st = RX_STOP;
							end
							default: begin
								n.rx_st = RX_IDLE;
								n.rhr = s.rx_shift;
								if (s.rx_ready && !rhr_rd) begin
									n.ovr = 1'h1;
								end
								if (!rx_in) begin
									n.frm = 1'h1;
								end
								if (has_check(s.chk) && s.rx_chk !=
									check_bit(s.chk, s.rx_shift)) begin
									n.perr = 1'h1;
								end
								n.rx_ready = 1'h1;
							end
						endcase
					end
				end
			endcase
		end
		if (s.rx_stop_pend && n.rx_st == RX_IDLE) begin
			n.rx_on = 1'h0;
			n.rx_stop_pend = 1'h0;
			n.rx_sub = 4'h0;
		end

		// Register writes
		if (cmd_wr) begin
			if (wdat[RECEIVER_ON_CMD_BIT] && !wdat[RECEIVER_OFF_CMD_BIT]) begin
				n.rx_on = 1'h1;
				n.rx_stop_pend = 1'h0;
			end
			if (wdat[RECEIVER_OFF_CMD_BIT]) begin
				if (n.rx_st == RX_IDLE) begin
					n.rx_on = 1'h0;
					n.rx_sub = 4'h0;
				end else begin
					n.rx_stop_pend = 1'h1;
				end
			end
			if (wdat[RECEIVER_RESET_CMD_BIT]) begin
				n.rx_on = 1'h0;
				n.rx_stop_pend = 1'h0;
				n.rx_st = RX_IDLE;
				n.rx_sub = 4'h0;
			end
			if (wdat[TRANSMITTER_ON_CMD_BIT] &&
				!wdat[TRANSMITTER_OFF_CMD_BIT]) begin
				n.tx_on = 1'h1;
				n.tx_stop_pend = 1'h0;
			end
			if (wdat[TRANSMITTER_OFF_CMD_BIT]) begin
				if (n.tx_st == TX_IDLE && !n.thr_full) begin
					n.tx_on = 1'h0;
				end else begin
					n.tx_stop_pend = 1'h1;
				end
			end
			if (wdat[TRANSMITTER_RESET_CMD_BIT]) begin
				n.tx_on = 1'h0;
				n.tx_stop_pend = 1'h0;
				n.tx_st = TX_IDLE;
				n.tx_sub = 4'h0;
				n.thr_full = 1'h0;
				n.tx_line = 1'h1;
			end
		end else if (wr && hits(wb_adr_i, OFS_LINE_MODE)) begin
			mv = (mode_word & ~wmask) | (wdat & MODE_VALID);
			n.chk = mv[CHECK_BIT_KIND_LSB +: 3];
			n.chan = mv[CHANNEL_TEST_SELECT_LSB +: 2];
		end else if (ier_wr) begin
			n.mask = s.mask | ier_bits;
		end else if (idr_wr) begin
			n.mask = s.mask & ~idr_bits;
		end else if (wr && hits(wb_adr_i, OFS_TX_HOLDING)) begin
			n.thr = wdat[7:0];
			n.thr_full = 1'h1;
		end else if (wr && hits(wb_adr_i, OFS_BAUD_DIVISOR)) begin
			n.divisor = (s.divisor & ~wmask[15:0]) | wdat[15:0];
		end

		// Read data
		if (rd) begin
			if (hits(wb_adr_i, OFS_LINE_MODE)) begin
				n.dat = mode_word;
			end else if (hits(wb_adr_i, OFS_IRQ_MASK)) begin
				n.dat = s.mask;
			end else if (hits(wb_adr_i, OFS_LINE_STATUS)) begin
				n.dat = stat;
			end else if (hits(wb_adr_i, OFS_RX_HOLDING)) begin
				n.dat = {24'h00_0000, s.rhr};
			end else if (hits(wb_adr_i, OFS_BAUD_DIVISOR)) begin
				n.dat = {16'h0000, s.divisor};
			end else begin
				n.dat = 32'h0000_0000;
			end
		end

		// Pin routing
		case (s.chan)
			CH_NORMAL: n.txd = n.tx_line;
			CH_LOCAL: n.txd = 1'h1;
			default: n.txd = serial_in_pin;
		endcase
		n.irq = irq_src;
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			s <= URI_STATE_RESET;
		end else if (clk_en) begin
			s <= n;
		end
	end

	assign wb_ack_o = s.ack;
	assign wb_dat_o = s.dat;
	assign serial_out_pin = s.txd;
	assign irq_out = s.irq;

	// ****************************************
	// Checks
	// ****************************************
	a_rx_reset_off: assert property (@(posedge clock) disable iff (!resetn)
		(clk_en && cmd_wr && wdat[RECEIVER_RESET_CMD_BIT]) |=>
		(!s.rx_on && s.rx_st == RX_IDLE))
		else $error("receiver still running after reset command");
	a_tx_reset_off: assert property (@(posedge clock) disable iff (!resetn)
		(clk_en && cmd_wr && wdat[TRANSMITTER_RESET_CMD_BIT]) |=>
		(!s.tx_on && !s.thr_full && s.tx_st == TX_IDLE))
		else $error("transmitter still running after reset command");
	a_rx_on_prio: assert property (@(posedge clock) disable iff (!resetn)
		(clk_en && cmd_wr && wdat[RECEIVER_ON_CMD_BIT]) |=>
		(s.rx_on == !$past(wdat[RECEIVER_OFF_CMD_BIT]) ||
		$past(wdat[RECEIVER_RESET_CMD_BIT]) ||
		(s.rx_on && s.rx_stop_pend)))
		else $error("receiver enable priority wrong");
	a_rx_finish: assert property (@(posedge clock) disable iff (!resetn)
		(clk_en && cmd_wr && wdat[RECEIVER_OFF_CMD_BIT] &&
		!wdat[RECEIVER_RESET_CMD_BIT] && s.rx_st == RX_DATA) |=>
		(s.rx_on && s.rx_stop_pend))
		else $error("receiver stopped mid character");
	a_tx_on_prio: assert property (@(posedge clock) disable iff (!resetn)
		(clk_en && cmd_wr && wdat[TRANSMITTER_ON_CMD_BIT] &&
		!wdat[TRANSMITTER_OFF_CMD_BIT] &&
		!wdat[TRANSMITTER_RESET_CMD_BIT]) |=> s.tx_on)
		else $error("transmitter not enabled");
	a_tx_drain: assert property (@(posedge clock) disable iff (!resetn)
		(clk_en && cmd_wr && wdat[TRANSMITTER_OFF_CMD_BIT] &&
		!wdat[TRANSMITTER_RESET_CMD_BIT] && s.thr_full) |=>
		(s.tx_on && s.thr_full))
		else $error("transmitter stopped with held character");
	a_stat_clear: assert property (@(posedge clock) disable iff (!resetn)
		(clk_en && cmd_wr && wdat[STATUS_CLEAR_CMD_BIT] &&
		s.rx_st != RX_STOP) |=> (!s.ovr && !s.frm && !s.perr))
		else $error("sticky flags not cleared");
	a_mask_set: assert property (@(posedge clock) disable iff (!resetn)
		(clk_en && ier_wr) |=>
		((s.mask & $past(ier_bits)) == $past(ier_bits)))
		else $error("enable write did not set mask");
	a_mask_clear: assert property (@(posedge clock) disable iff (!resetn)
		(clk_en && idr_wr) |=> ((s.mask & $past(idr_bits)) == 0))
		else $error("disable write did not clear mask");
	a_rhr_clear: assert property (@(posedge clock) disable iff (!resetn)
		(clk_en && rhr_rd && s.rx_st != RX_STOP) |=> !s.rx_ready)
		else $error("receiver ready not cleared by read");
	a_baud_stop: assert property (@(posedge clock) disable iff (!resetn)
		(clk_en && s.divisor == BAUD_RESET) |=> !s.tick)
		else $error("baud tick with zero divisor");
	a_irq_follow: assert property (@(posedge clock) disable iff (!resetn)
		clk_en |=> (irq_out == $past(irq_src)))
		else $error("interrupt output not following status and mask");
	a_ack_pulse: assert property (@(posedge clock) disable iff (!resetn)
		(clk_en && wb_ack_o) |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
endmodule // uri_top

/* hdl/uri_pkg.sv */
// Purpose: Constants and types of the serial port register block
// Assumes: Byte addresses on a 32-bit classic Wishbone slave
// Notes: Reset values and layouts shared by design and bench
package uri_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam int ADDR_W = 12;
	localparam logic [11:0] OFS_COMMAND = 12'h000;
	localparam logic [11:0] OFS_LINE_MODE = 12'h004;
	localparam logic [11:0] OFS_IRQ_ENABLE = 12'h008;
	localparam logic [11:0] OFS_IRQ_DISABLE = 12'h00C;
	localparam logic [11:0] OFS_IRQ_MASK = 12'h010;
	localparam logic [11:0] OFS_LINE_STATUS = 12'h014;
	localparam logic [11:0] OFS_RX_HOLDING = 12'h018;
	localparam logic [11:0] OFS_TX_HOLDING = 12'h01C;
	localparam logic [11:0] OFS_BAUD_DIVISOR = 12'h020;
	// ****************************************
	// Command bits
	// ****************************************
	localparam int RECEIVER_RESET_CMD_BIT = 2;
	localparam int TRANSMITTER_RESET_CMD_BIT = 3;
	localparam int RECEIVER_ON_CMD_BIT = 4;
	localparam int RECEIVER_OFF_CMD_BIT = 5;
	localparam int TRANSMITTER_ON_CMD_BIT = 6;
	localparam int TRANSMITTER_OFF_CMD_BIT = 7;
	localparam int STATUS_CLEAR_CMD_BIT = 8;
	// ****************************************
	// Mode fields
	// ****************************************
	localparam int CHECK_BIT_KIND_LSB = 9;
	localparam int CHANNEL_TEST_SELECT_LSB = 14;
	localparam logic [31:0] MODE_VALID = 32'h0000_CE00;
	localparam logic [31:0] MODE_RESET = 32'h0000_0000;
	// ****************************************
	// Status bits, shared by mask registers
	// ****************************************
	localparam int RECEIVER_READY_FLAG_BIT = 0;
	localparam int HOLDING_FREE_FLAG_BIT = 1;
	localparam int RX_DMA_DONE_FLAG_BIT = 3;
	localparam int TX_DMA_DONE_FLAG_BIT = 4;
	localparam int OVERRUN_FLAG_BIT = 5;
	localparam int FRAMING_FLAG_BIT = 6;
	localparam int PARITY_ERROR_FLAG_BIT = 7;
	localparam int TRANSMIT_IDLE_FLAG_BIT = 9;
	localparam int TX_DMA_BUFFER_EMPTY_FLAG_BIT = 11;
	localparam int RX_DMA_BUFFER_FULL_FLAG_BIT = 12;
	localparam logic [31:0] IRQ_VALID = 32'h0000_1AFB;
	localparam logic [31:0] MASK_RESET = 32'h0000_0000;
	localparam logic [7:0] RHR_RESET = 8'h00;
	localparam logic [15:0] BAUD_RESET = 16'h0000;
	// ****************************************
	// Timing: 16 samples per bit
	// ****************************************
	localparam logic [3:0] TICK_LAST = 4'hF;
	localparam logic [3:0] START_LOW_LAST = 4'h7;
	localparam logic [2:0] DATA_BITS_LAST = 3'h7;
	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [2:0] {
		CHK_EVEN = 3'h0, CHK_ODD = 3'h1, CHK_SPACE = 3'h2,
		CHK_MARK = 3'h3, CHK_NONE = 3'h4
	} uri_chk_t;
	typedef enum logic [1:0] {
		CH_NORMAL = 2'h0, CH_ECHO = 2'h1,
		CH_LOCAL = 2'h2, CH_REMOTE = 2'h3
	} uri_chan_t;
	typedef enum logic [2:0] {
		TX_IDLE = 3'h0, TX_START = 3'h1, TX_DATA = 3'h2,
		TX_CHECK = 3'h3, TX_STOP = 3'h4
	} uri_tx_t;
	typedef enum logic [1:0] {
		RX_IDLE = 2'h0, RX_DATA = 2'h1, RX_CHECK = 2'h2, RX_STOP = 2'h3
	} uri_rx_t;
	typedef struct packed {
		logic ack;
		logic [31:0] dat;
		logic irq;
		logic txd;
		logic rx_on;
		logic tx_on;
		logic rx_stop_pend;
		logic tx_stop_pend;
		logic [2:0] chk;
		logic [1:0] chan;
		logic [31:0] mask;
		logic [7:0] rhr;
		logic rx_ready;
		logic ovr;
		logic frm;
		logic perr;
		logic [15:0] divisor;
		logic [15:0] div_cnt;
		logic tick;
		logic [7:0] thr;
		logic thr_full;
		uri_tx_t tx_st;
		logic [3:0] tx_sub;
		logic [2:0] tx_bit;
		logic [7:0] tx_shift;
		logic tx_chk;
		logic tx_line;
		uri_rx_t rx_st;
		logic [3:0] rx_sub;
		logic [2:0] rx_bit;
		logic [7:0] rx_shift;
		logic rx_chk;
	} uri_state_t;
	localparam uri_state_t URI_STATE_RESET = '{
		tx_st: TX_IDLE, rx_st: RX_IDLE,
		txd: 1'h1, tx_line: 1'h1, default: '0
	};
endpackage

/* bench/uri_partner.sv */
// Purpose: Far serial device sending characters to the port
// Assumes: Line idles high; bit time given in clocks
// Notes: Even check bit; flip_par sends a wrong one
`timescale 1ns/1ps
module uri_partner
	import uri_pkg::*;
(
	input wire logic clock,
	output logic serial_line
);
	// ****
	// Sender
	// ****
	int bit_clks = 16;
	initial serial_line = 1'b1;
	task automatic send(input logic [7:0] d, input logic flip_par,
		input logic stop_val);
		logic [10:0] f;
		f = {stop_val, ^d ^ flip_par, d, 1'b0};
		for (int i = 0; i < 11; i++) begin
			@(posedge clock);
			serial_line <= f[i];
			// Stop bit cut just past mid-bit: a low tail would pose as a start
			repeat ((i == 10) ? bit_clks / 2 + 2 : bit_clks - 1)
				@(posedge clock);
		end
		// Idle gap before the next start
		@(posedge clock);
		serial_line <= 1'b1;
		repeat (bit_clks - 1) @(posedge clock);
	endtask
endmodule // uri_partner

/* bench/uri_top_tb.sv */
// Purpose: Self-checking bench of the serial port registers
// Assumes: One ack per access, divisor 1 gives 16 clocks a bit
// Notes: Frame timing checked at mid-bit only
`timescale 1ns/1ps
module uri_top_tb import uri_pkg::*;;
	// ****
	// Signals
	// ****
	logic clock, resetn, clk_en, wb_cyc_i, wb_stb_i, wb_we_i;
	logic [ADDR_W-1:0] wb_adr_i;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, wb_dat_o, rd;
	logic wb_ack_o, serial_in_pin, serial_out_pin, irq_out;
	logic rx_dma_done, tx_dma_done, tx_dma_buffer_empty, rx_dma_buffer_full;
	logic [10:0] f;
	int num_errors = 0;
	int checked = 0;
	uri_top DUT (.clock(clock), .resetn(resetn), .clk_en(clk_en),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
		.rx_dma_done(rx_dma_done), .tx_dma_done(tx_dma_done),
		.tx_dma_buffer_empty(tx_dma_buffer_empty),
		.rx_dma_buffer_full(rx_dma_buffer_full), .irq_out(irq_out));
	uri_partner u_far (.clock(clock), .serial_line(serial_in_pin));
	// ****
	// Helpers
	// ****
	task automatic give_verdict();
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic expect_eq(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: %s %h not %h", $time, what, got, exp);
		end
	endtask
	// Request held until ack is sampled high, never a fixed wait
	task automatic wb_xfer(input logic we, input logic [ADDR_W-1:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			@(posedge clock);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		rd = wb_dat_o;
		if (n >= 50) expect_eq(32'h0000_0000, 32'h0000_0001, "no ack");
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		wb_xfer(1'b1, a, d);
	endtask
	task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
		wb_xfer(1'b0, a, 32'h0000_0000);
		expect_eq(rd, e, "read");
	endtask
	task automatic grab_frame(input int bclk);
		int n;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (serial_out_pin !== 1'b0 && n < 2000);
		repeat (bclk / 2) @(posedge clock);
		f[0] = serial_out_pin;
		for (int i = 1; i < 11; i++) begin
			repeat (bclk) @(posedge clock);
			f[i] = serial_out_pin;
		end
		repeat (bclk) @(posedge clock);
	endtask
	// ****
	// Scenarios
	// ****
	task automatic t_reset();
		rdchk(OFS_LINE_MODE, MODE_RESET);
		rdchk(OFS_IRQ_MASK, MASK_RESET);
		rdchk(OFS_RX_HOLDING, 32'h0000_0000);
		rdchk(OFS_BAUD_DIVISOR, 32'h0000_0000);
		rdchk(OFS_LINE_STATUS, 32'h0000_0000);
		wr(12'h100, 32'hFFFF_FFFF);
		rdchk(OFS_IRQ_MASK, MASK_RESET);
		rdchk(12'h100, 32'h0000_0000);
	endtask
	task automatic t_mode();
		logic [31:0] v;
		for (int k = 0; k < 5; k++)
			for (int c = 0; c < 4; c++) begin
				v = 32'(k) << CHECK_BIT_KIND_LSB | 32'(c) << CHANNEL_TEST_SELECT_LSB;
				wr(OFS_LINE_MODE, v);
				rdchk(OFS_LINE_MODE, v);
			end
		wr(OFS_LINE_MODE, 32'hFFFF_FFFF);
		rdchk(OFS_LINE_MODE, MODE_VALID);
		wr(OFS_LINE_MODE, MODE_RESET);
	endtask
	task automatic t_irq();
		wr(OFS_IRQ_ENABLE, 32'hFFFF_FFFF);
		rdchk(OFS_IRQ_MASK, IRQ_VALID);
		wr(OFS_IRQ_DISABLE, 32'h0000_1AFA);
		wr(OFS_IRQ_ENABLE, 32'h0000_0000);
		rdchk(OFS_IRQ_MASK, 32'h0000_0001);
		wr(OFS_IRQ_DISABLE, 32'h0000_0001);
		rx_dma_done <= 1'b1;
		tx_dma_done <= 1'b1;
		tx_dma_buffer_empty <= 1'b1;
		rx_dma_buffer_full <= 1'b1;
		rdchk(OFS_LINE_STATUS, 32'h0000_1818);
		expect_eq(32'(irq_out), 32'h0000_0000, "irq");
		wr(OFS_IRQ_ENABLE, 32'h0000_1000);
		repeat (2) @(posedge clock);
		expect_eq(32'(irq_out), 32'h0000_0001, "irq");
		// Clock enable low freezes the registered interrupt
		clk_en <= 1'b0;
		rx_dma_buffer_full <= 1'b0;
		repeat (3) @(posedge clock);
		expect_eq(32'(irq_out), 32'h0000_0001, "frozen irq");
		clk_en <= 1'b1;
		repeat (2) @(posedge clock);
		expect_eq(32'(irq_out), 32'h0000_0000, "irq");
		rx_dma_buffer_full <= 1'b1;
		wr(OFS_IRQ_DISABLE, 32'h0000_1000);
		repeat (2) @(posedge clock);
		expect_eq(32'(irq_out), 32'h0000_0000, "irq");
		rx_dma_done <= 1'b0;
		tx_dma_done <= 1'b0;
		tx_dma_buffer_empty <= 1'b0;
		rx_dma_buffer_full <= 1'b0;
	endtask
	task automatic t_tx();
		wr(OFS_BAUD_DIVISOR, 32'h0000_0001);
		rdchk(OFS_BAUD_DIVISOR, 32'h0000_0001);
		wr(OFS_COMMAND, 32'h0000_00C0);
		rdchk(OFS_LINE_STATUS, 32'h0000_0000);
		wr(OFS_COMMAND, 32'h0000_0040);
		rdchk(OFS_LINE_STATUS, 32'h0000_0202);
		wr(OFS_TX_HOLDING, 32'h0000_00A5);
		wr(OFS_COMMAND, 32'h0000_0080);
		grab_frame(16);
		expect_eq(32'(f), 32'({1'b1, ^8'hA5, 8'hA5, 1'b0}), "frame");
		rdchk(OFS_LINE_STATUS, 32'h0000_0000);
		wr(OFS_COMMAND, 32'h0000_0040);
		wr(OFS_TX_HOLDING, 32'h0000_0000);
		repeat (40) @(posedge clock);
		wr(OFS_COMMAND, 32'h0000_0008);
		repeat (3) @(posedge clock);
		expect_eq(32'(serial_out_pin), 32'h0000_0001, "line");
		rdchk(OFS_LINE_STATUS, 32'h0000_0000);
		// Divisor 0 must hold the character back entirely
		wr(OFS_BAUD_DIVISOR, 32'h0000_0000);
		wr(OFS_COMMAND, 32'h0000_0040);
		wr(OFS_TX_HOLDING, 32'h0000_003C);
		repeat (100) @(posedge clock);
		expect_eq(32'(serial_out_pin), 32'h0000_0001, "line");
		rdchk(OFS_LINE_STATUS, 32'h0000_0000);
		// Stop asked while a character is still held
		wr(OFS_COMMAND, 32'h0000_0080);
		wr(OFS_BAUD_DIVISOR, 32'h0000_0002);
		grab_frame(32);
		expect_eq(32'(f), 32'({1'b1, ^8'h3C, 8'h3C, 1'b0}), "frame");
		rdchk(OFS_LINE_STATUS, 32'h0000_0000);
		wr(OFS_COMMAND, 32'h0000_0008);
	endtask
	task automatic t_rx();
		wr(OFS_BAUD_DIVISOR, 32'h0000_0001);
		wr(OFS_COMMAND, 32'h0000_0010);
		u_far.send(8'h3C, 1'b0, 1'b1);
		rdchk(OFS_LINE_STATUS, 32'h0000_0001);
		rdchk(OFS_RX_HOLDING, 32'h0000_003C);
		rdchk(OFS_LINE_STATUS, 32'h0000_0000);
		u_far.send(8'h11, 1'b0, 1'b1);
		u_far.send(8'h22, 1'b0, 1'b1);
		rdchk(OFS_LINE_STATUS, 32'h0000_0021);
		u_far.send(8'h33, 1'b1, 1'b1);
		rdchk(OFS_LINE_STATUS, 32'h0000_00A1);
		u_far.send(8'h44, 1'b0, 1'b0);
		rdchk(OFS_LINE_STATUS, 32'h0000_00E1);
		wr(OFS_COMMAND, 32'h0000_0100);
		rdchk(OFS_LINE_STATUS, 32'h0000_0001);
		rdchk(OFS_RX_HOLDING, 32'h0000_0044);
		fork
			u_far.send(8'h5A, 1'b0, 1'b1);
			begin
				repeat (60) @(posedge clock);
				wr(OFS_COMMAND, 32'h0000_0020);
			end
		join
		rdchk(OFS_LINE_STATUS, 32'h0000_0000);
		rdchk(OFS_RX_HOLDING, 32'h0000_005A);
		wr(OFS_COMMAND, 32'h0000_0030);
		u_far.send(8'h77, 1'b0, 1'b1);
		rdchk(OFS_RX_HOLDING, 32'h0000_005A);
		wr(OFS_COMMAND, 32'h0000_0010);
		fork
			u_far.send(8'h66, 1'b0, 1'b1);
			begin
				repeat (60) @(posedge clock);
				wr(OFS_COMMAND, 32'h0000_0004);
			end
		join
		rdchk(OFS_RX_HOLDING, 32'h0000_005A);
		rdchk(OFS_LINE_STATUS, 32'h0000_0000);
		// Local loopback: line held high, own character comes back
		wr(OFS_LINE_MODE, 32'h0000_8000);
		wr(OFS_COMMAND, 32'h0000_0050);
		wr(OFS_TX_HOLDING, 32'h0000_00C3);
		repeat (100) @(posedge clock);
		expect_eq(32'(serial_out_pin), 32'h0000_0001, "line");
		repeat (100) @(posedge clock);
		rdchk(OFS_LINE_STATUS, 32'h0000_0203);
		rdchk(OFS_RX_HOLDING, 32'h0000_00C3);
	endtask
	// ****
	// Run
	// ****
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	initial begin
		// Several times the few thousand cycles the scenarios need
		#400_000;
		expect_eq(32'h0000_0000, 32'h0000_0001, "watchdog");
		give_verdict();
	end
	initial begin
		resetn = 1'b0;
		clk_en = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = '0;
		wb_sel_i = 4'hF;
		wb_dat_i = '0;
		rx_dma_done = 1'b0;
		tx_dma_done = 1'b0;
		tx_dma_buffer_empty = 1'b0;
		rx_dma_buffer_full = 1'b0;
		repeat (4) @(posedge clock);
		resetn <= 1'b1;
		t_reset();
		t_mode();
		t_irq();
		t_tx();
		t_rx();
		give_verdict();
	end
endmodule // uri_top_tb
